// >>> rtl/csc_consts.vh
/*
  Constants of the clamp status, temperature channel and reference control block:
  register offsets, field positions, reset values and serial command figures.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH

// Register offsets (8-bit data, word per offset)
`define CSC_OFS_STATUS 4'h0
`define CSC_OFS_CLAMP_LOW 4'h1
`define CSC_OFS_CLAMP_HIGH 4'h2
`define CSC_OFS_REF_CTRL 4'h3
`define CSC_OFS_TEMP_CTRL 4'h4
`define CSC_OFS_STAT_CFG 4'h5
`define CSC_OFS_MODE 4'h6
`define CSC_OFS_SEQ_LAST 4'h7
`define CSC_OFS_IRQ_STAT 4'h8
`define CSC_OFS_IRQ_MASK 4'h9

// Status register fields
`define CSC_STATUS_SUMMARY 0
`define CSC_STATUS_COMMON 1

// Reference control fields
`define CSC_REF_OVERVOLTAGE_CURRENT_MODE_SEL 0
`define CSC_REF_RANGE_LSB 1
`define CSC_REF_RANGE_MSB 3
`define CSC_REF_RANGE_MAX 3'h4

// Temperature control and status-bit configuration
`define CSC_TEMP_EN 0
`define CSC_CFG_ALERT_OR_THR 0

// Interrupt event bits
`define CSC_IRQ_SUMMARY 0
`define CSC_IRQ_COMMON 1
`define CSC_IRQ_RESULT 2

// Reset values
`define CSC_RST_REF_CTRL 8'h00
`define CSC_RST_TEMP_CTRL 8'h00
`define CSC_RST_STAT_CFG 8'h00
`define CSC_RST_MODE 3'h0
`define CSC_RST_SEQ_LAST 4'hF
`define CSC_RST_IRQ_MASK 8'h00

// Operating modes
`define CSC_MODE_CFG 3'h0
`define CSC_MODE_STD 3'h1
`define CSC_MODE_ADV 3'h2
`define CSC_MODE_TWO 3'h3
`define CSC_MODE_ONE 3'h4

// Serial channel command
`define CSC_CMD_BITS 5
`define CSC_TEMP_CODE 5'h0F

`endif

// >>> rtl/csc_sync.v
/*
  Two flip-flop synchroniser, one chain per bit.
  Assumes inputs are asynchronous to i_clk; only the second stage is read outside.
*/
`timescale 1ns/100ps
module csc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Data
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge i_clk) begin
        if (i_rst) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
        end else begin
          stage1[g] <= i_async[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate
  assign o_sync = stage2;
endmodule

// >>> rtl/csc_top.v
/*
  Clamp flags, overvoltage alert, temperature channel scheduling and reference
  range control of a multiplexed SAR converter, with a plain register port.
  Assumes clamp levels, serial pins and the convert pin are asynchronous and
  the SAR core answers each conversion start with one result valid pulse.
*/
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "csc_consts.vh"
module csc_top #(
  parameter CHANNELS = 16,
  parameter RESULT_W = 16
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Analog clamp comparators
  input wire [CHANNELS-1:0] i_clamp_active,
  input wire i_common_clamp_active,
  // Serial port pins and convert pin
  input wire i_sck,
  input wire i_sdi,
  input wire i_cs_n,
  input wire i_cnv,
  // SAR core and threshold detector
  input wire [RESULT_W-1:0] i_sar_result,
  input wire i_sar_valid,
  input wire i_thresh_alert,
  // Multiplexer and core control
  output reg [3:0] o_mux_channel,
  output reg o_mux_temp_sensor,
  output reg o_mux_neg_reference_ground_node,
  output reg o_ainhiz_force,
  output reg o_oversampling_ratio_force_one,
  output reg o_thresh_enable,
  output reg o_conv_start,
  // Reference control
  output reg o_overvoltage_current_mode_sel,
  output reg [2:0] o_vref_range,
  // Conversion result
  output reg [RESULT_W-1:0] o_result,
  output reg o_result_valid,
  output reg o_result_temp,
  output reg o_overvoltage_alert_status_bit,
  // Interrupt
  output reg o_irq
);
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  // Synchronised pins
  wire [CHANNELS+4:0] pins_sync;
  wire [CHANNELS-1:0] per_input_clamp_flag;
  wire common_input_clamp_flag;
  wire sck_s;
  wire sdi_s;
  wire cs_n_s;
  wire cnv_s;

  csc_sync #(
    .WIDTH(CHANNELS + 5)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_cnv, i_cs_n, i_sdi, i_sck, i_common_clamp_active, i_clamp_active}),
    .o_sync(pins_sync)
  );

  assign per_input_clamp_flag = pins_sync[CHANNELS-1:0];
  assign common_input_clamp_flag = pins_sync[CHANNELS];
  assign sck_s = pins_sync[CHANNELS+1];
  assign sdi_s = pins_sync[CHANNELS+2];
  assign cs_n_s = pins_sync[CHANNELS+3];
  assign cnv_s = pins_sync[CHANNELS+4];

  // Registers
  reg summary_clamp_flag;
  reg [7:0] ref_ctrl;
  reg [7:0] temp_ctrl;
  reg [7:0] stat_cfg;
  reg [2:0] mode;
  reg [3:0] seq_last;
  reg [7:0] irq_stat;
  reg [7:0] irq_mask;
  reg sck_d;
  reg cnv_d;
  reg summary_d;
  reg common_d;
  reg [2:0] bit_cnt;
  reg [`CSC_CMD_BITS-1:0] cmd_shift;
  reg [`CSC_CMD_BITS-1:0] cmd_code;
  reg [3:0] seq_idx;
  reg seq_temp;
  reg state;

  wire any_clamp = |per_input_clamp_flag;
  wire sck_rise = sck_s & ~sck_d;
  wire cnv_rise = cnv_s & ~cnv_d;
  wire cmd_mode = (mode == `CSC_MODE_TWO) || (mode == `CSC_MODE_ONE);
  wire seq_mode = (mode == `CSC_MODE_STD) || (mode == `CSC_MODE_ADV);
  wire rd_status = i_rd && (i_addr == `CSC_OFS_STATUS);
  wire rd_irq = i_rd && (i_addr == `CSC_OFS_IRQ_STAT);
  wire [7:0] irq_events;
  wire [7:0] next_irq_stat;

  // Serial command code selects the temperature sensor
  function is_temp_code;
    input [`CSC_CMD_BITS-1:0] code;
    begin
      is_temp_code = (code == `CSC_TEMP_CODE);
    end
  endfunction

  // Which register slot an address writes; decoded once per register
  function wr_hit;
    input [3:0] addr;
    input [3:0] ofs;
    input wr;
    begin
      wr_hit = wr && (addr == ofs);
    end
  endfunction

  // Summary flag: set wins over the clearing read
  always @(posedge i_clk) begin
    if (i_rst) begin
      summary_clamp_flag <= 1'b0;
    end else if (any_clamp) begin
      summary_clamp_flag <= 1'b1;
    end else if (rd_status) begin
      summary_clamp_flag <= 1'b0;
    end
  end

  // Software-written control registers
  always @(posedge i_clk) begin
    if (i_rst) begin
      ref_ctrl <= `CSC_RST_REF_CTRL;
      temp_ctrl <= `CSC_RST_TEMP_CTRL;
      stat_cfg <= `CSC_RST_STAT_CFG;
      mode <= `CSC_RST_MODE;
      seq_last <= `CSC_RST_SEQ_LAST;
      irq_mask <= `CSC_RST_IRQ_MASK;
    end else begin
      if (wr_hit(i_addr, `CSC_OFS_REF_CTRL, i_wr)) begin
        ref_ctrl <= {4'h0, i_wdata[`CSC_REF_RANGE_MSB:0]};
      end
      if (wr_hit(i_addr, `CSC_OFS_TEMP_CTRL, i_wr)) begin
        temp_ctrl <= {7'h00, i_wdata[`CSC_TEMP_EN]};
      end
      if (wr_hit(i_addr, `CSC_OFS_STAT_CFG, i_wr)) begin
        stat_cfg <= {7'h00, i_wdata[`CSC_CFG_ALERT_OR_THR]};
      end
      if (wr_hit(i_addr, `CSC_OFS_MODE, i_wr)) begin
        mode <= i_wdata[2:0];
      end
      if (wr_hit(i_addr, `CSC_OFS_SEQ_LAST, i_wr)) begin
        seq_last <= i_wdata[3:0];
      end
      if (wr_hit(i_addr, `CSC_OFS_IRQ_MASK, i_wr)) begin
        irq_mask <= i_wdata;
      end
    end
  end

  // Reference controls leave on flip-flops
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_overvoltage_current_mode_sel <= 1'b0;
      o_vref_range <= 3'h0;
    end else begin
      o_overvoltage_current_mode_sel <= ref_ctrl[`CSC_REF_OVERVOLTAGE_CURRENT_MODE_SEL];
      // Codes past the fifth option are clamped so the reference stays defined
      if (ref_ctrl[`CSC_REF_RANGE_MSB:`CSC_REF_RANGE_LSB] > `CSC_REF_RANGE_MAX) begin
        o_vref_range <= `CSC_REF_RANGE_MAX;
      end else begin
        o_vref_range <= ref_ctrl[`CSC_REF_RANGE_MSB:`CSC_REF_RANGE_LSB];
      end
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `CSC_OFS_STATUS: begin
          o_rdata <= {6'h00, common_input_clamp_flag, summary_clamp_flag | any_clamp};
        end
        `CSC_OFS_CLAMP_LOW: begin
          o_rdata <= per_input_clamp_flag[7:0];
        end
        `CSC_OFS_CLAMP_HIGH: begin
          o_rdata <= per_input_clamp_flag[15:8];
        end
        `CSC_OFS_REF_CTRL: begin
          o_rdata <= ref_ctrl;
        end
        `CSC_OFS_TEMP_CTRL: begin
          o_rdata <= temp_ctrl;
        end
        `CSC_OFS_STAT_CFG: begin
          o_rdata <= stat_cfg;
        end
        `CSC_OFS_MODE: begin
          o_rdata <= {5'h00, mode};
        end
        `CSC_OFS_SEQ_LAST: begin
          o_rdata <= {4'h0, seq_last};
        end
        `CSC_OFS_IRQ_STAT: begin
          o_rdata <= irq_stat;
        end
        `CSC_OFS_IRQ_MASK: begin
          o_rdata <= irq_mask;
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Serial command capture: first five rising clock edges of each frame
  always @(posedge i_clk) begin
    if (i_rst) begin
      sck_d <= 1'b0;
      bit_cnt <= 3'h0;
      cmd_shift <= 5'h00;
      cmd_code <= 5'h00;
    end else begin
      sck_d <= sck_s;
      if (cs_n_s) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise && (bit_cnt < `CSC_CMD_BITS)) begin
        bit_cnt <= bit_cnt + 3'h1;
        cmd_shift <= {cmd_shift[`CSC_CMD_BITS-2:0], sdi_s};
        if (bit_cnt == (`CSC_CMD_BITS - 1)) begin
          cmd_code <= {cmd_shift[`CSC_CMD_BITS-2:0], sdi_s};
        end
      end
    end
  end

  // Conversion control and sequencer
  always @(posedge i_clk) begin
    if (i_rst) begin
      cnv_d <= 1'b0;
      state <= ST_IDLE;
      seq_idx <= 4'h0;
      seq_temp <= 1'b0;
      o_mux_channel <= 4'h0;
      o_mux_temp_sensor <= 1'b0;
      o_mux_neg_reference_ground_node <= 1'b0;
      o_ainhiz_force <= 1'b0;
      o_oversampling_ratio_force_one <= 1'b0;
      o_thresh_enable <= 1'b0;
      o_conv_start <= 1'b0;
      o_result <= {RESULT_W{1'b0}};
      o_result_valid <= 1'b0;
      o_result_temp <= 1'b0;
      o_overvoltage_alert_status_bit <= 1'b0;
    end else begin
      cnv_d <= cnv_s;
      o_conv_start <= 1'b0;
      o_result_valid <= 1'b0;
      if (!seq_mode) begin
        seq_idx <= 4'h0;
        seq_temp <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          // Configuration mode never starts conversions
          if (cnv_rise && (seq_mode || cmd_mode)) begin
            state <= ST_BUSY;
            o_conv_start <= 1'b1;
            if (seq_mode) begin
              o_mux_channel <= seq_idx;
              o_mux_temp_sensor <= seq_temp;
              o_mux_neg_reference_ground_node <= seq_temp;
              o_ainhiz_force <= seq_temp;
              o_oversampling_ratio_force_one <= seq_temp;
              o_thresh_enable <= ~seq_temp;
            end else begin
              o_mux_channel <= cmd_code[3:0];
              o_mux_temp_sensor <= is_temp_code(cmd_code);
              o_mux_neg_reference_ground_node <= is_temp_code(cmd_code);
              o_ainhiz_force <= is_temp_code(cmd_code);
              o_oversampling_ratio_force_one <= is_temp_code(cmd_code);
              o_thresh_enable <= ~is_temp_code(cmd_code);
            end
          end
        end
        ST_BUSY: begin
          if (i_sar_valid) begin
            state <= ST_IDLE;
            // Temperature codes pass untouched: unipolar, ratio one
            o_result <= i_sar_result;
            o_result_valid <= 1'b1;
            o_result_temp <= o_mux_temp_sensor;
            o_overvoltage_alert_status_bit <= any_clamp |
              (stat_cfg[`CSC_CFG_ALERT_OR_THR] & i_thresh_alert & o_thresh_enable);
            if (seq_mode) begin
              if (seq_temp) begin
                seq_temp <= 1'b0;
                seq_idx <= 4'h0;
              end else if (seq_idx >= seq_last) begin
                seq_idx <= 4'h0;
                seq_temp <= temp_ctrl[`CSC_TEMP_EN];
              end else begin
                seq_idx <= seq_idx + 4'h1;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Interrupts: sticky events, cleared by reading, set wins
  assign irq_events = {5'h00, o_result_valid, common_input_clamp_flag & ~common_d,
    summary_clamp_flag & ~summary_d};
  assign next_irq_stat = (rd_irq ? 8'h00 : irq_stat) | irq_events;

  always @(posedge i_clk) begin
    if (i_rst) begin
      summary_d <= 1'b0;
      common_d <= 1'b0;
      irq_stat <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      summary_d <= summary_clamp_flag;
      common_d <= common_input_clamp_flag;
      irq_stat <= next_irq_stat;
      o_irq <= |(next_irq_stat & irq_mask);
    end
  end
endmodule

// >>> sim/csc_top_assertions.sv
/*
  Port checks on csc_top: read slot, reset state, clamp flags, results, temp routing.
  Assumes the bench holds clamp pins steady for several cycles around reads.
*/
`timescale 1ns/100ps
`include "csc_consts.vh"
module csc_chk #(
  parameter CHANNELS = 16,
  parameter RESULT_W = 16
) (
  // Clock, reset and register port
  input wire i_clk,
  input wire i_rst,
  input wire [3:0] i_addr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  // Clamps, core and outputs
  input wire [CHANNELS-1:0] i_clamp_active,
  input wire i_common_clamp_active,
  input wire [RESULT_W-1:0] i_sar_result,
  input wire i_sar_valid,
  input wire i_thresh_alert,
  input wire o_mux_temp_sensor,
  input wire o_mux_neg_reference_ground_node,
  input wire o_ainhiz_force,
  input wire o_oversampling_ratio_force_one,
  input wire o_thresh_enable,
  input wire o_conv_start,
  input wire o_overvoltage_current_mode_sel,
  input wire [2:0] o_vref_range,
  input wire [RESULT_W-1:0] o_result,
  input wire o_result_valid,
  input wire o_overvoltage_alert_status_bit
);
  reg [CHANNELS:0] prev;
  reg [2:0] calm;
  // Pins pass a synchroniser, so flags are judged only once the pins have settled
  always @(posedge i_clk) begin
    prev <= {i_common_clamp_active, i_clamp_active};
    if (i_rst || prev != {i_common_clamp_active, i_clamp_active})
      calm <= 3'h0;
    else if (calm != 3'h7)
      calm <= calm + 3'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_ov_rst;
    $past(i_rst) |-> !o_overvoltage_current_mode_sel && o_vref_range == 3'h0;
  endproperty
  a_ov_rst: assert property (p_ov_rst)
    else $error("reference control not at reset value");
  property p_sum_rd;
    i_rd && i_addr == `CSC_OFS_STATUS && |i_clamp_active && calm > 3'h3 |=> o_rdata[0];
  endproperty
  a_sum_rd: assert property (p_sum_rd)
    else $error("summary flag low with clamp active");
  property p_com_rd;
    i_rd && i_addr == `CSC_OFS_STATUS && calm > 3'h3 |=> o_rdata[1] == $past(i_common_clamp_active);
  endproperty
  a_com_rd: assert property (p_com_rd)
    else $error("common flag wrong");
  property p_low_rd;
    i_rd && i_addr == `CSC_OFS_CLAMP_LOW && calm > 3'h3 |=> o_rdata == $past(i_clamp_active[7:0]);
  endproperty
  a_low_rd: assert property (p_low_rd)
    else $error("clamp flags wrong");
  property p_alert;
    o_result_valid && calm > 3'h3 && !$past(i_thresh_alert)
      |-> o_overvoltage_alert_status_bit == |i_clamp_active;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert bit wrong");
  property p_route;
    o_conv_start |-> o_mux_neg_reference_ground_node == o_mux_temp_sensor;
  endproperty
  a_route: assert property (p_route)
    else $error("negative side routing wrong");
  property p_force;
    o_conv_start && o_mux_temp_sensor |-> o_ainhiz_force && o_oversampling_ratio_force_one;
  endproperty
  a_force: assert property (p_force)
    else $error("temp conversion not forced");
  property p_no_thr;
    o_conv_start && o_mux_temp_sensor |-> !o_thresh_enable;
  endproperty
  a_no_thr: assert property (p_no_thr)
    else $error("threshold enabled for temp");
  property p_result;
    i_sar_valid |=> o_result_valid && o_result == $past(i_sar_result);
  endproperty
  a_result: assert property (p_result)
    else $error("result not passed");
endmodule

// >>> sim/csc_host.sv
/*
  Serial host model: shifts a five-bit channel code and pulses the convert pin.
  Assumes the caller waits for each task; timing is unrelated to the block clock.
*/
`timescale 1ns/100ps
module csc_host (
  output logic o_sck,
  output logic o_sdi,
  output logic o_cs_n,
  output logic o_cnv
);
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
    o_cs_n = 1'b1;
    o_cnv = 1'b0;
  end
  task automatic send(input logic [4:0] code);
    integer k;
    #37 o_cs_n = 1'b0;
    for (k = 4; k >= 0; k--) begin
      o_sdi = code[k];
      #400 o_sck = 1'b1;
      #400 o_sck = 1'b0;
    end
    o_cs_n = 1'b1;
    // A released line must not keep showing the last bit
    o_sdi = ~o_sdi;
  endtask
  task automatic pulse_cnv();
    #53 o_cnv = 1'b1;
    #400 o_cnv = 1'b0;
  endtask
endmodule

// >>> sim/testbench.sv
/*
  Self-checking bench for csc_top with a serial host model.
  Assumes reads answer one cycle late and the core model answers each start.
*/
`timescale 1ns/100ps
`include "csc_consts.vh"
module testbench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_clamp_active = 16'h0000;
  logic i_common_clamp_active = 1'b0;
  logic [15:0] i_sar_result = 16'h0000;
  logic i_sar_valid = 1'b0;
  logic i_thresh_alert = 1'b0;
  wire sck, sdi, cs_n, cnv, tmp, neg, hiz, osr1, thr, cst, ov, rv, rt, alert, irq;
  wire [7:0] rdata;
  wire [3:0] ch_o;
  wire [2:0] rng;
  wire [15:0] res;
  integer mismatches = 0;
  integer total_checks = 0;
  always #50 i_clk = ~i_clk;
  csc_host host(.o_sck(sck), .o_sdi(sdi), .o_cs_n(cs_n), .o_cnv(cnv));
  csc_top #(.CHANNELS(16), .RESULT_W(16)) DUT(.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata(rdata), .i_clamp_active, .i_common_clamp_active, .i_sck(sck),
    .i_sdi(sdi), .i_cs_n(cs_n), .i_cnv(cnv), .i_sar_result, .i_sar_valid, .i_thresh_alert,
    .o_mux_channel(ch_o), .o_mux_temp_sensor(tmp), .o_mux_neg_reference_ground_node(neg),
    .o_ainhiz_force(hiz), .o_oversampling_ratio_force_one(osr1), .o_thresh_enable(thr),
    .o_conv_start(cst), .o_overvoltage_current_mode_sel(ov), .o_vref_range(rng),
    .o_result(res), .o_result_valid(rv), .o_result_temp(rt),
    .o_overvoltage_alert_status_bit(alert), .o_irq(irq));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic pins(input logic [15:0] c, input logic m, input logic t);
    @(posedge i_clk);
    i_clamp_active <= c;
    i_common_clamp_active <= m;
    i_thresh_alert <= t;
    repeat (6) @(posedge i_clk);
  endtask
  task automatic conv(input logic [3:0] ch, input logic t, input logic al);
    integer n;
    // A pulse still high from the last call would hide this rising edge
    wait (cnv == 1'b0);
    @(posedge i_clk);
    fork
      host.pulse_cnv();
    join_none
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (!cst && n < 40);
    chk({15'h0000, cst}, 16'h0001);
    chk({11'h000, t ? 4'h0 : ch_o, tmp}, {11'h000, ch, t});
    if (t) chk({12'h000, neg, hiz, osr1, thr}, 16'h000E);
    @(posedge i_clk);
    i_sar_result <= {ch, 12'h5A3};
    i_sar_valid <= 1'b1;
    @(posedge i_clk);
    i_sar_valid <= 1'b0;
    #1 chk(res, {ch, 12'h5A3});
    chk({13'h0000, rv, rt, alert}, {13'h0000, 1'b1, t, al});
  endtask
  task automatic t_regs();
    integer k;
    #1 chk({14'h0000, ov, irq}, 16'h0000);
    rd(`CSC_OFS_REF_CTRL, 8'h00);
    rd(4'hF, 8'h00);
    for (k = 0; k < 8; k++) begin
      wr(`CSC_OFS_REF_CTRL, {4'h0, k[2:0], k[0]});
      // Reference outputs follow the register one edge later
      @(posedge i_clk);
      #1 chk({12'h000, ov, rng}, {12'h000, k[0], (k > 4) ? 3'h4 : k[2:0]});
    end
  endtask
  task automatic t_clamps();
    pins(16'h1008, 1'b0, 1'b0);
    #1 chk({15'h0000, irq}, 16'h0000);
    wr(`CSC_OFS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge i_clk);
    #1 chk({15'h0000, irq}, 16'h0001);
    rd(`CSC_OFS_CLAMP_LOW, 8'h08);
    rd(`CSC_OFS_CLAMP_HIGH, 8'h10);
    rd(`CSC_OFS_STATUS, 8'h01);
    rd(`CSC_OFS_STATUS, 8'h01);
    rd(`CSC_OFS_IRQ_STAT, 8'h01);
    repeat (2) @(posedge i_clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    pins(16'h0000, 1'b1, 1'b0);
    rd(`CSC_OFS_CLAMP_LOW, 8'h00);
    rd(`CSC_OFS_STATUS, 8'h03);
    rd(`CSC_OFS_STATUS, 8'h02);
    pins(16'h0000, 1'b0, 1'b0);
    rd(`CSC_OFS_STATUS, 8'h00);
  endtask
  task automatic t_seq();
    wr(`CSC_OFS_SEQ_LAST, 8'h01);
    wr(`CSC_OFS_TEMP_CTRL, 8'h01);
    wr(`CSC_OFS_MODE, 8'h01);
    pins(16'h0020, 1'b0, 1'b0);
    conv(4'h0, 1'b0, 1'b1);
    conv(4'h1, 1'b0, 1'b1);
    conv(4'h0, 1'b1, 1'b1);
    conv(4'h0, 1'b0, 1'b1);
    pins(16'h0000, 1'b0, 1'b1);
    wr(`CSC_OFS_STAT_CFG, 8'h01);
    // Advanced sequencer keeps the linear order and the current position
    wr(`CSC_OFS_MODE, 8'h02);
    conv(4'h1, 1'b0, 1'b1);
    conv(4'h0, 1'b1, 1'b0);
  endtask
  task automatic t_cmd();
    integer m;
    pins(16'h0000, 1'b0, 1'b0);
    for (m = 3; m < 5; m++) begin
      wr(`CSC_OFS_MODE, m[7:0]);
      host.send(`CSC_TEMP_CODE);
      conv(4'h0, 1'b1, 1'b0);
      host.send(5'h09);
      conv(4'h9, 1'b0, 1'b0);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_clamps();
    t_seq();
    t_cmd();
    test_done();
  end
  // Whole run needs well under a tenth of this span
  initial begin
    #2_000_000;
    mismatches++;
    test_done();
  end
endmodule
bind csc_top csc_chk #(.CHANNELS(CHANNELS), .RESULT_W(RESULT_W)) u_chk(.i_clk, .i_rst,
  .i_addr, .i_rd, .o_rdata, .i_clamp_active, .i_common_clamp_active, .i_sar_result,
  .i_sar_valid, .i_thresh_alert, .o_mux_temp_sensor, .o_mux_neg_reference_ground_node,
  .o_ainhiz_force, .o_oversampling_ratio_force_one, .o_thresh_enable, .o_conv_start,
  .o_overvoltage_current_mode_sel, .o_vref_range, .o_result, .o_result_valid,
  .o_overvoltage_alert_status_bit);
